// ==== hw/usc_pin_sync.sv ====
// Two-stage synchroniser for pin inputs, with one extra stage for edge finding.
// Assumes the pins change with no relation to the system clock.
`timescale 1ns/1ps
module usc_pin_sync #(
   parameter int W = 3
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync,
   output logic      [W-1:0] o_prev
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } usc_sync_t;

   usc_sync_t st;
   usc_sync_t next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = i_async;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_sync = st.s2;
   assign o_prev = st.s3;
endmodule : usc_pin_sync

// ==== hw/usc_pkg.sv ====
// Constants shared by the universal serial control block.
// Assumes a single 125 MHz system clock and an 8-bit register port.
// Operation
// - Overflow interrupt enable plus pending flag and global enable raise the interrupt at once.
// - Wire mode zero leaves all three pins as plain port pins.
// - Three-wire mode drives the data output pin from the latch, direction bit still rules.
// - Three-wire mode leaves data-in and clock pins as port pins; masters toggle the clock.
// - Two-wire data pin is open drain, pulled low when latch or port bit is zero.
// - Two-wire clock pin is pulled low by port bit zero or a pending start flag.
// - Two-wire mode turns both bus pull-ups off; inputs stay unchanged.
// - Wire mode three also holds the clock low while the overflow flag is set.
// - Inputs clock and feed the shifter in every wire mode.
// - External clock moves the output latch on the opposite edge; internal clocks pass it through.
// - Clock source zero clocks on the software strobe only; source one on timer-zero match.
// - External clock shifts on rising or falling edge; counter counts both edges or toggles.
// - Software strobe shifts once and counts once, output changing in that cycle.
// - With external clock the strobe bit selects toggle strobes as counter clock.
// - Strobe and toggle bits always read as zero.
// - Writing the toggle bit inverts the clock pin port bit whatever its direction.
// - External clock with strobe select set makes each toggle write count once.
// - Overflow flag sets on wrap from fifteen to zero and clears by writing one.
// - Two-wire start condition sets the start flag, cleared only by writing one.
// - The data output comes through the latch from the shift register top bit.
package usc_pkg;
   // ---------------------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------------------
   localparam int         ADDR_W     = 4;
   localparam logic [3:0] A_CTRL     = 4'h0;
   localparam logic [3:0] A_STATUS   = 4'h1;
   localparam logic [3:0] A_DATA     = 4'h2;
   localparam logic [3:0] A_PORT     = 4'h3;
   localparam logic [3:0] A_DIR      = 4'h4;
   localparam logic [3:0] A_PIN      = 4'h5;
   // ---------------------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------------------
   localparam int B_START_IE = 7;
   localparam int B_OVF_IE   = 6;
   localparam int B_WM_HI    = 5;
   localparam int B_WM_LO    = 4;
   localparam int B_CS_HI    = 3;
   localparam int B_CS_LO    = 2;
   localparam int B_STROBE   = 1;
   localparam int B_TOGGLE   = 0;
   // ---------------------------------------------------------------------------
   // Status register fields
   // ---------------------------------------------------------------------------
   localparam int B_START_F  = 7;
   localparam int B_OVF_F    = 6;
   localparam int B_CNT_HI   = 3;
   // ---------------------------------------------------------------------------
   // Wire modes, clock sources, pin indices, reset values
   // ---------------------------------------------------------------------------
   localparam logic [1:0] WM_OFF     = 2'h0;
   localparam logic [1:0] WM_THREE   = 2'h1;
   localparam logic [1:0] WM_TWO_HLD = 2'h3;
   localparam logic [1:0] CS_SOFT    = 2'h0;
   localparam logic [1:0] CS_TIMER   = 2'h1;
   localparam int         NPINS      = 3;
   localparam int         P_DI       = 0;
   localparam int         P_DO       = 1;
   localparam int         P_SCK      = 2;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [2:0] RST_PINS   = 3'h0;
   localparam logic [3:0] CNT_MAX    = 4'hf;
endpackage : usc_pkg

// ==== hw/usc_serial_ctrl.sv ====
// Control logic of the universal serial interface: wire modes, clock select, pin drivers.
// Assumes a register port on the system clock and pins from outside that clock's domain.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module usc_serial_ctrl (
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_rst,
   input  wire logic [usc_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [7:0]                 i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   output logic      [7:0]                 o_rdata,
   input  wire logic                       i_timer_zero_match,
   input  wire logic                       i_global_irq_enable,
   output logic                            o_overflow_irq,
   input  wire logic [usc_pkg::NPINS-1:0]  i_pin,
   output logic      [usc_pkg::NPINS-1:0]  o_pin_out,
   output logic      [usc_pkg::NPINS-1:0]  o_pin_oe,
   output logic      [usc_pkg::NPINS-1:0]  o_pin_pullup
);
   import usc_pkg::*;

   default clocking cb_sys @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   // ---------------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------------
   typedef struct packed {
      logic             start_ie;
      logic             ovf_ie;
      logic [1:0]       wm;
      logic [1:0]       cs;
      logic             clk_sel;
      logic [NPINS-1:0] port;
      logic [NPINS-1:0] ddr;
      logic             start_flag;
      logic             ovf_flag;
      logic             do_latch;
      logic [7:0]       rdata;
   } usc_ctl_t;

   usc_ctl_t st;
   usc_ctl_t next_st;

   logic [NPINS-1:0] pin_s;
   logic [NPINS-1:0] pin_p;
   logic [7:0]       data;
   logic [3:0]       cnt;
   logic             ovf_pulse;
   logic             wr_ctrl;
   logic             wr_status;
   logic             wr_data;
   logic             sck_rise;
   logic             sck_fall;
   logic             sda_fall;
   logic             two_wire;
   logic             ext_clk;
   logic             sw_strobe;
   logic             toggle;
   logic             toggle_cnt;
   logic             shift_en;
   logic             cnt_en;
   logic             sample_edge;
   logic             latch_edge;
   logic             latch_out;
   logic             start_evt;
   logic             scl_hold;

   // ---------------------------------------------------------------------------
   // Pin synchronisers and the shifter
   // ---------------------------------------------------------------------------
   usc_pin_sync #(
      .W (NPINS)
   ) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_async   (i_pin),
      .o_sync    (pin_s),
      .o_prev    (pin_p)
   );

   usc_shift_counter u_shift (
      .i_sys_clk    (i_sys_clk),
      .i_rst        (i_rst),
      .i_shift      (shift_en),
      .i_count      (cnt_en),
      .i_serial_in  (pin_s[P_DI]),
      .i_data_wr    (wr_data),
      .i_data_wdata (i_wdata),
      .i_cnt_wr     (wr_status),
      .i_cnt_wdata  (i_wdata[B_CNT_HI:0]),
      .o_data       (data),
      .o_count      (cnt),
      .o_overflow   (ovf_pulse)
   );

   // ---------------------------------------------------------------------------
   // Clock selection
   // ---------------------------------------------------------------------------
   assign wr_ctrl   = i_wr & (i_addr == A_CTRL);
   assign wr_status = i_wr & (i_addr == A_STATUS);
   assign wr_data   = i_wr & (i_addr == A_DATA);
   assign sck_rise  = pin_s[P_SCK] & ~pin_p[P_SCK];
   assign sck_fall  = ~pin_s[P_SCK] & pin_p[P_SCK];
   assign sda_fall  = ~pin_s[P_DI] & pin_p[P_DI];
   assign two_wire  = st.wm[1];
   assign ext_clk   = st.cs[1];

   // Strobe and toggle act only on the write cycle; the strobe bit is stored only as clk_sel when an external clock is written.
   assign sw_strobe  = wr_ctrl & i_wdata[B_STROBE] & (i_wdata[B_CS_HI:B_CS_LO] == CS_SOFT);
   assign toggle     = wr_ctrl & i_wdata[B_TOGGLE];
   assign toggle_cnt = toggle & i_wdata[B_CS_HI] & i_wdata[B_STROBE];

   // Inputs feed the shifter whatever the wire mode.
   assign sample_edge = st.cs[0] ? sck_fall : sck_rise;
   assign latch_edge  = st.cs[0] ? sck_rise : sck_fall;

   // A strobe acts with the clock source written beside it, so changing source and strobing at once is not lost.
   always_comb begin
      shift_en = sw_strobe;
      cnt_en   = sw_strobe | toggle_cnt;
      unique case (st.cs)
         CS_SOFT: begin
            shift_en = sw_strobe;
         end
         CS_TIMER: begin
            shift_en = sw_strobe | i_timer_zero_match;
            cnt_en   = sw_strobe | toggle_cnt | i_timer_zero_match;
         end
         default: begin
            shift_en = sw_strobe | sample_edge;
            cnt_en   = sw_strobe | toggle_cnt | (~st.clk_sel & (sck_rise | sck_fall));
         end
      endcase
   end

   // Internal clocks see the top bit at once; external clock sees the latch.
   assign latch_out = ext_clk ? st.do_latch : data[7];

   // Start condition in two-wire mode, any clock edge otherwise.
   assign start_evt = two_wire ? (sda_fall & pin_s[P_SCK]) : (sck_rise | sck_fall);
   assign scl_hold  = st.start_flag | ((st.wm == WM_TWO_HLD) & st.ovf_flag);

   // ---------------------------------------------------------------------------
   // Register updates
   // ---------------------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (wr_ctrl) begin
         next_st.start_ie = i_wdata[B_START_IE];
         next_st.ovf_ie   = i_wdata[B_OVF_IE];
         next_st.wm       = i_wdata[B_WM_HI:B_WM_LO];
         next_st.cs       = i_wdata[B_CS_HI:B_CS_LO];
         next_st.clk_sel  = i_wdata[B_CS_HI] & i_wdata[B_STROBE];
      end
      if (i_wr && (i_addr == A_PORT)) begin
         next_st.port = i_wdata[NPINS-1:0];
      end
      if (i_wr && (i_addr == A_DIR)) begin
         next_st.ddr = i_wdata[NPINS-1:0];
      end
      if (toggle) begin
         next_st.port[P_SCK] = ~st.port[P_SCK];
      end
      // Hardware set wins over a software clear in the same cycle.
      if (wr_status && i_wdata[B_OVF_F]) begin
         next_st.ovf_flag = 1'b0;
      end
      if (ovf_pulse) begin
         next_st.ovf_flag = 1'b1;
      end
      if (wr_status && i_wdata[B_START_F]) begin
         next_st.start_flag = 1'b0;
      end
      if (start_evt && (st.wm != WM_OFF || !two_wire)) begin
         next_st.start_flag = 1'b1;
      end
      if (ext_clk && latch_edge) begin
         next_st.do_latch = data[7];
      end
      next_st.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            A_CTRL: begin
               next_st.rdata = {st.start_ie, st.ovf_ie, st.wm, st.cs, 2'b00};
            end
            A_STATUS: begin
               next_st.rdata = {st.start_flag, st.ovf_flag, 2'b00, cnt};
            end
            A_DATA: begin
               next_st.rdata = data;
            end
            A_PORT: begin
               next_st.rdata = {5'h00, st.port};
            end
            A_DIR: begin
               next_st.rdata = {5'h00, st.ddr};
            end
            A_PIN: begin
               next_st.rdata = {5'h00, pin_s};
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------------------
   always_comb begin
      o_pin_out    = st.port;
      o_pin_oe     = st.ddr;
      o_pin_pullup = ~st.ddr & st.port;
      if (st.wm == WM_THREE) begin
         o_pin_out[P_DO] = latch_out;
      end else if (two_wire) begin
         o_pin_out[P_DI]    = 1'b0;
         o_pin_out[P_SCK]   = 1'b0;
         o_pin_oe[P_DI]     = st.ddr[P_DI] & (~latch_out | ~st.port[P_DI]);
         o_pin_oe[P_SCK]    = st.ddr[P_SCK] & (~st.port[P_SCK] | scl_hold);
         o_pin_pullup[P_DI]  = 1'b0;
         o_pin_pullup[P_SCK] = 1'b0;
      end
   end

   assign o_overflow_irq = st.ovf_ie & st.ovf_flag & i_global_irq_enable;
   assign o_rdata        = st.rdata;

   // ---------------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------------
   a_strobe_reads_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_rd && i_addr == A_CTRL) |=> (o_rdata[1:0] == 2'b00))
      else $error("strobe or toggle bit read back as one");

   a_irq_pending_now: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (wr_ctrl && i_wdata[B_OVF_IE] && st.ovf_flag && !wr_status && i_global_irq_enable)
      |=> (o_overflow_irq || !i_global_irq_enable))
      else $error("pending overflow did not raise the interrupt");

   a_mode_off_pins: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (st.wm == WM_OFF) |-> (o_pin_oe == st.ddr && o_pin_out == st.port))
      else $error("pins not plain port pins with wire mode off");

   a_sda_open_drain: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (two_wire && st.ddr[P_DI]) |-> (o_pin_oe[P_DI] == !(latch_out && st.port[P_DI])) && !o_pin_out[P_DI])
      else $error("data line drive wrong in two-wire mode");

   a_start_hold_scl: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (two_wire && st.ddr[P_SCK] && st.start_flag) |-> (o_pin_oe[P_SCK] && !o_pin_out[P_SCK]))
      else $error("clock not held low after start condition");

   a_ovf_hold_scl: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (ovf_pulse && st.wm == WM_TWO_HLD && st.ddr[P_SCK] && !(i_wr && i_addr == A_DIR)
       && !(wr_ctrl && i_wdata[B_WM_HI:B_WM_LO] != WM_TWO_HLD))
      |=> (o_pin_oe[P_SCK] && st.ovf_flag))
      else $error("clock not held low after counter overflow");

   a_pullups_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      two_wire |-> (o_pin_pullup[P_DI] == 1'b0 && o_pin_pullup[P_SCK] == 1'b0))
      else $error("pull-up left on in two-wire mode");

   a_soft_strobe_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      sw_strobe |=> (cnt == $past(cnt) + 4'h1 && data == {$past(data[6:0]), $past(pin_s[P_DI])}))
      else $error("software strobe did not shift and count once");

   a_toggle_inverts: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      toggle |=> (st.port[P_SCK] != $past(st.port[P_SCK])))
      else $error("toggle write did not invert the clock port bit");

   a_toggle_counts: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      toggle_cnt |=> (cnt == $past(cnt) + 4'h1))
      else $error("toggle write did not clock the counter");

   a_ovf_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (st.ovf_flag && !(wr_status && i_wdata[B_OVF_F])) |=> st.ovf_flag)
      else $error("overflow flag cleared without a write of one");

   a_ovf_sets_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      ovf_pulse |=> (st.ovf_flag && cnt == 4'h0))
      else $error("wrap to zero did not set the overflow flag");

   a_three_wire_pins: assert property (
      (st.wm == WM_THREE)
      |-> (o_pin_oe == st.ddr && o_pin_pullup == (~st.ddr & st.port)))
      else $error("three-wire pin drive or pull-up wrong");

   a_internal_out: assert property (
      (!ext_clk && st.wm == WM_THREE)
      |-> (o_pin_out[P_DO] == data[7]))
      else $error("data output does not follow the top bit");

   a_two_wire_drive: assert property (
      two_wire
      |-> (!o_pin_out[P_SCK] && (!o_pin_oe[P_SCK] || st.ddr[P_SCK])))
      else $error("clock line not open drain in two-wire mode");

   a_scl_released: assert property (
      (two_wire && st.port[P_SCK] && !st.start_flag && !(st.wm == WM_TWO_HLD && st.ovf_flag))
      |-> !o_pin_oe[P_SCK])
      else $error("clock line held low with no cause");

   a_start_sets_flag: assert property (
      (two_wire && start_evt)
      |=> st.start_flag)
      else $error("start condition did not set the start flag");

   a_soft_no_clock: assert property (
      (st.cs == CS_SOFT && !i_wr)
      |=> (cnt == $past(cnt) && data == $past(data)))
      else $error("shifter clocked with no strobe");

   a_timer_step: assert property (
      (st.cs == CS_TIMER && i_timer_zero_match && !i_wr)
      |=> (cnt == $past(cnt) + 4'h1 && data == {$past(data[6:0]), $past(pin_s[P_DI])}))
      else $error("timer match did not shift and count once");

   a_ext_shift: assert property (
      (ext_clk && sample_edge && !i_wr)
      |=> (data == {$past(data[6:0]), $past(pin_s[P_DI])}))
      else $error("external clock edge did not shift");

   a_ext_count_edges: assert property (
      (ext_clk && !st.clk_sel && (sck_rise || sck_fall) && !i_wr)
      |=> (cnt == $past(cnt) + 4'h1))
      else $error("external clock edge not counted");

   a_strobe_sel_hold: assert property (
      (ext_clk && st.clk_sel && !i_wr)
      |=> (cnt == $past(cnt)))
      else $error("counter moved without a toggle strobe");

   a_latch_holds: assert property (
      (ext_clk && st.wm == WM_THREE && !latch_edge && !wr_ctrl)
      |=> $stable(o_pin_out[P_DO]))
      else $error("output latch changed off its edge");
endmodule : usc_serial_ctrl

// ==== hw/usc_shift_counter.sv ====
// Eight-bit left shift register with a four-bit counter beside it.
// Assumes one-cycle enables from the control logic on the same clock.
`timescale 1ns/1ps
module usc_shift_counter (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_shift,
   input  wire logic       i_count,
   input  wire logic       i_serial_in,
   input  wire logic       i_data_wr,
   input  wire logic [7:0] i_data_wdata,
   input  wire logic       i_cnt_wr,
   input  wire logic [3:0] i_cnt_wdata,
   output logic      [7:0] o_data,
   output logic      [3:0] o_count,
   output logic            o_overflow
);
   import usc_pkg::*;

   typedef struct packed {
      logic [7:0] data;
      logic [3:0] cnt;
   } usc_sc_t;

   usc_sc_t st;
   usc_sc_t next_st;

   always_comb begin
      next_st = st;
      // A write in the same cycle as a shift keeps the written value.
      if (i_data_wr) begin
         next_st.data = i_data_wdata;
      end else if (i_shift) begin
         next_st.data = {st.data[6:0], i_serial_in};
      end
      if (i_cnt_wr) begin
         next_st.cnt = i_cnt_wdata;
      end else if (i_count) begin
         next_st.cnt = st.cnt + 4'h1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_data     = st.data;
   assign o_count    = st.cnt;
   assign o_overflow = i_count & ~i_cnt_wr & (st.cnt == CNT_MAX);
endmodule : usc_shift_counter

// ==== test/tb.sv ====
// Self-checking testbench of the serial control block, register port tasks and a link partner.
// Assumes the register map and field layout of the design package.
`timescale 1ns/1ps
module tb;
   import usc_pkg::*;
   logic       clk;
   logic       rst;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       tmatch;
   logic       girq;
   logic       irq;
   logic [2:0] pin;
   logic [2:0] pout;
   logic [2:0] poe;
   logic [2:0] ppu;
   logic       bus_pu;
   int         errors;
   int         compares;

   usc_serial_ctrl uut (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_timer_zero_match(tmatch), .i_global_irq_enable(girq), .o_overflow_irq(irq),
      .i_pin(pin), .o_pin_out(pout), .o_pin_oe(poe), .o_pin_pullup(ppu));
   usc_bus_partner peer (.i_pin_out(pout), .i_pin_oe(poe), .i_pin_pullup(ppu), .i_bus_pullup(bus_pu), .o_pin(pin));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ---------------------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(n, rdata, e);
   endtask : reg_rd

   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle

   task automatic pins(input logic [2:0] eo, input logic [2:0] ep);
      settle();
      chk("pin enable", {5'h00, poe}, {5'h00, eo});
      chk("pin pullup", {5'h00, ppu}, {5'h00, ep});
   endtask : pins

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   initial begin
      #200000;
      errors++;
      $display("watchdog expired");
      report_and_stop();
   end

   // ---------------------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------------------
   initial begin
      rst = 1'b1; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
      tmatch = 1'b0; girq = 1'b0; bus_pu = 1'b0; errors = 0; compares = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 5; a++) reg_rd(a[3:0], 8'h00, "reset value");
      reg_wr(4'h7, 8'hff);
      reg_rd(4'h7, 8'h00, "unmapped");
      $display("test reset done");
      reg_wr(A_CTRL, 8'hfb);
      reg_rd(A_CTRL, 8'hf8, "control");
      reg_rd(A_PORT, 8'h04, "port");
      reg_rd(A_STATUS, 8'h01, "status");
      reg_wr(A_CTRL, 8'h09);
      reg_rd(A_PORT, 8'h00, "port");
      reg_rd(A_STATUS, 8'h01, "status");
      $display("test strobes done");
      reg_wr(A_CTRL, 8'h00); reg_wr(A_PORT, 8'h07); reg_wr(A_DIR, 8'h06);
      pins(3'h6, 3'h1);
      chk("pin out", {5'h00, pout}, 8'h07);
      reg_rd(A_PIN, 8'h07, "pin levels");
      reg_wr(A_CTRL, 8'h10); reg_wr(A_DATA, 8'h00);
      pins(3'h6, 3'h1);
      chk("pin out", {5'h00, pout}, 8'h05);
      reg_wr(A_DIR, 8'h04);
      pins(3'h4, 3'h3);
      reg_wr(A_DATA, 8'h80); reg_wr(A_DIR, 8'h06); settle();
      chk("pin out", {5'h00, pout}, 8'h07);
      $display("test pin modes done");
      reg_wr(A_PORT, 8'h01); reg_wr(A_DIR, 8'h03); reg_wr(A_DATA, 8'h81); reg_wr(A_STATUS, 8'hc0);
      reg_wr(A_CTRL, 8'h12);
      reg_rd(A_DATA, 8'h03, "shift data");
      settle();
      chk("pin out", {5'h00, pout}, 8'h01);
      reg_rd(A_STATUS, 8'h01, "status");
      reg_wr(A_CTRL, 8'h10);
      reg_rd(A_STATUS, 8'h01, "status");
      reg_wr(A_CTRL, 8'h14);
      @(posedge clk) tmatch <= 1'b1;
      @(posedge clk) tmatch <= 1'b0;
      reg_rd(A_STATUS, 8'h02, "status");
      reg_rd(A_DATA, 8'h07, "shift data");
      reg_wr(A_STATUS, 8'h0f);
      @(posedge clk) girq <= 1'b1;
      reg_wr(A_CTRL, 8'h12);
      reg_rd(A_STATUS, 8'h40, "status");
      settle();
      chk("irq", {7'h00, irq}, 8'h00);
      reg_wr(A_CTRL, 8'h50); settle();
      chk("irq", {7'h00, irq}, 8'h01);
      reg_wr(A_STATUS, 8'h00);
      reg_rd(A_STATUS, 8'h40, "status");
      reg_wr(A_STATUS, 8'h40); settle();
      chk("irq", {7'h00, irq}, 8'h00);
      $display("test internal clocks done");
      @(posedge clk) bus_pu <= 1'b1;
      reg_wr(A_CTRL, 8'h20); reg_wr(A_PORT, 8'h05); reg_wr(A_DIR, 8'h05); reg_wr(A_DATA, 8'h80);
      reg_wr(A_STATUS, 8'hc0);
      pins(3'h0, 3'h0);
      peer.start_cond();
      reg_rd(A_STATUS, 8'h80, "status");
      pins(3'h4, 3'h0);
      reg_wr(A_DATA, 8'h00);
      pins(3'h5, 3'h0);
      reg_wr(A_CTRL, 8'h30); reg_wr(A_STATUS, 8'hcf);
      pins(3'h1, 3'h0);
      reg_wr(A_CTRL, 8'h32);
      reg_rd(A_STATUS, 8'h40, "status");
      pins(3'h5, 3'h0);
      reg_wr(A_STATUS, 8'h40);
      pins(3'h1, 3'h0);
      $display("test two-wire done");
      @(posedge clk) bus_pu <= 1'b0;
      reg_wr(A_CTRL, 8'h18); reg_wr(A_DIR, 8'h02); reg_wr(A_DATA, 8'h00); settle();
      reg_wr(A_STATUS, 8'hc0);
      peer.send_byte(8'ha5); settle();
      reg_rd(A_DATA, 8'ha5, "shift data");
      reg_rd(A_STATUS, 8'hc0, "status");
      chk("data out", {7'h00, pout[1]}, 8'h01);
      reg_wr(A_CTRL, 8'h0c); reg_wr(A_STATUS, 8'hc0);
      peer.send_byte(8'h3c); settle();
      reg_rd(A_DATA, 8'h3c, "shift data");
      reg_rd(A_STATUS, 8'hc0, "status");
      $display("test external clock done");
      report_and_stop();
   end
endmodule : tb

// ==== test/usc_bus_partner.sv ====
// Behavioural far-side party of the serial interface: a link master that clocks bytes in or makes a start condition.
// Assumes the tb tells it whether the bus carries external pull-ups (two-wire) and calls its tasks hierarchically.
`timescale 1ns/1ps
module usc_bus_partner (
   input  wire logic [2:0] i_pin_out,
   input  wire logic [2:0] i_pin_oe,
   input  wire logic [2:0] i_pin_pullup,
   input  wire logic       i_bus_pullup,
   output logic      [2:0] o_pin
);
   logic       sck_v   = 1'b0;
   logic       sda_v   = 1'b0;
   logic       sda_en  = 1'b0;
   logic       float_v = 1'b0;
   logic [2:0] drv;
   logic [2:0] val;
   logic [2:0] bus_pu;

   // An undriven line with no pull-up wanders, so a stale level is never mistaken for data.
   always #20 float_v = ~float_v;

   // ---------------------------------------------------------------------------
   // Wire resolution
   // ---------------------------------------------------------------------------
   always_comb begin
      drv    = {~i_bus_pullup, 1'b0, sda_en};
      val    = {sck_v, 1'b0, sda_v};
      bus_pu = {i_bus_pullup, 1'b0, i_bus_pullup};
      for (int p = 0; p < 3; p++) begin
         if (i_pin_oe[p]) o_pin[p] = i_pin_out[p];
         else if (drv[p]) o_pin[p] = val[p];
         else if (i_pin_pullup[p] | bus_pu[p]) o_pin[p] = 1'b1;
         else o_pin[p] = float_v ^ p[0];
      end
   end

   // ---------------------------------------------------------------------------
   // Transfers
   // ---------------------------------------------------------------------------
   // The clock stands still low between frames; data is steady around both clock edges.
   task automatic send_byte(input logic [7:0] b);
      sda_en = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         sda_v = b[i];
         #40;
         sck_v = 1'b1;
         #80;
         sck_v = 1'b0;
         #40;
      end
      sda_en = 1'b0;
   endtask : send_byte

   // Data falls while the clock line is released high.
   task automatic start_cond();
      sda_v  = 1'b0;
      sda_en = 1'b1;
      #80;
      sda_en = 1'b0;
   endtask : start_cond
endmodule : usc_bus_partner
